// [logic/tsxr_top.v]
`timescale 1ns/1ps
`include "tsxr_regs.vh"

// ----------------------------------------------------------------
// Translation search and external context register bank.
// Software moves reach it through a register-number port; the
// translation logic reads the context and match results from it.
// ----------------------------------------------------------------
module tsxr_top #(
	parameter PID_W  = 14,   // Configured process ID width.
	parameter LPID_W = 12,   // Configured partition ID width.
	parameter RPU_W  = 8     // Real page bits beyond 32 implemented.
)(
	// Clock and reset.
	input  wire                I_CORE_CLK,
	input  wire                I_RSTN,
	// Register move port.
	input  wire                I_SPR_WR,
	input  wire                I_SPR_RD,
	input  wire [9:0]          I_SPR_NUM,
	input  wire [63:0]         I_SPR_WDATA,
	input  wire                I_HV_STATE,
	output reg  [63:0]         O_SPR_RDATA,
	output reg                 O_SPR_ACK,
	output reg                 O_PRIV_EXC,
	// Sibling assist registers (entry control, select, real page low).
	input  wire [31:0]         I_SEL_REG,
	input  wire [31:0]         I_ECTL_REG,
	input  wire [31:0]         I_RPL_REG,
	output reg                 O_SEL_WR,
	output reg                 O_ECTL_WR,
	output reg                 O_RPL_WR,
	output reg  [31:0]         O_SIB_WDATA,
	output reg  [31:0]         O_SEL_WDATA,
	// Translation side: entry candidate and machine state.
	input  wire [PID_W-1:0]    I_ENT_PID,
	input  wire                I_ENT_TS,
	input  wire                I_ENT_TGS,
	input  wire [LPID_W-1:0]   I_ENT_LPID,
	input  wire                I_MSR_PR,
	input  wire                I_MSR_DS,
	input  wire                I_MSR_GS,
	input  wire [LPID_W-1:0]   I_PART_ID,
	input  wire [PID_W-1:0]    I_CUR_PID,
	input  wire                I_EXT_LD,
	input  wire                I_EXT_ST,
	input  wire                I_DATA_ACC,
	// Results.
	output reg                 O_SEARCH_HIT,
	output reg                 O_XLATE_HIT,
	output reg                 O_EFF_PR,
	output reg                 O_VF_DSI,
	output reg  [RPU_W-1:0]    O_RPN_UPPER,
	output reg                 O_TAG_GS,
	output reg  [LPID_W-1:0]   O_TAG_LPID
);

	// ----------------------------------------------------------------
	// Reset release through two flops.
	// ----------------------------------------------------------------
	reg rst_s1_q;   // First stage, read only by the second.
	reg rst_n;      // Synchronised reset.

	// Asynchronous assert, synchronous release.
	always @(posedge I_CORE_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// Decode.
	// ----------------------------------------------------------------
	// Returns 1 when a register number needs hypervisor state.
	function hv_only;
		input [9:0] n;
		begin
			hv_only = (n == `TSXR_SPR_TAG) || (n == `TSXR_SPR_P_SRCH) ||
				(n == `TSXR_SPR_P_TAG) || (n == `TSXR_SPR_HSRCH);
		end
	endfunction

	wire acc      = I_SPR_WR | I_SPR_RD;                   // Any move.
	wire denied   = acc & hv_only(I_SPR_NUM) & ~I_HV_STATE;
	wire wr_ok    = I_SPR_WR & ~denied;                    // Permitted write.
	wire [31:0] wl = I_SPR_WDATA[31:0];                    // Low word.
	wire [31:0] wh = I_SPR_WDATA[63:32];                   // High word.

	// Which store each write lands in; pairs split across halves.
	wire w_srch = wr_ok & ((I_SPR_NUM == `TSXR_SPR_SRCH) ||
		(I_SPR_NUM == `TSXR_SPR_P_SRCH));
	wire w_hs   = wr_ok & ((I_SPR_NUM == `TSXR_SPR_HSRCH) ||
		(I_SPR_NUM == `TSXR_SPR_P_SRCH));
	wire w_tag  = wr_ok & ((I_SPR_NUM == `TSXR_SPR_TAG) ||
		(I_SPR_NUM == `TSXR_SPR_P_TAG));
	wire w_rph  = wr_ok & ((I_SPR_NUM == `TSXR_SPR_RPH) ||
		(I_SPR_NUM == `TSXR_SPR_P_RPN));
	wire w_ld   = wr_ok & (I_SPR_NUM == `TSXR_SPR_LDCTX);
	wire w_st   = wr_ok & (I_SPR_NUM == `TSXR_SPR_STCTX);

	// Source word for each store (pair high or low half).
	wire [31:0] d_srch = (I_SPR_NUM == `TSXR_SPR_P_SRCH) ? wl : wl;
	wire [31:0] d_hs   = (I_SPR_NUM == `TSXR_SPR_P_SRCH) ? wh : wl;
	wire [31:0] d_tag  = (I_SPR_NUM == `TSXR_SPR_P_TAG) ? wh : wl;
	wire [31:0] d_rph  = (I_SPR_NUM == `TSXR_SPR_P_RPN) ? wh : wl;

	// ----------------------------------------------------------------
	// Register storage, implemented bits only.
	// ----------------------------------------------------------------
	reg [PID_W-1:0]  search_process_id_q;   // Search process ID.
	reg              sas_q;    // Search space bit.
	reg              sgs_q;    // Hypervisor search guest bit.
	reg [LPID_W-1:0] slpid_q;  // Hypervisor search partition ID.
	reg              tgs_q;    // Entry guest space.
	reg              vf_q;     // Virtualization fault.
	reg [LPID_W-1:0] entry_partition_id_q;  // Entry partition ID.
	reg [RPU_W-1:0]  rpu_q;    // Upper real page bits.

	// Writes; the search pair lands both halves here in one cycle, the tag and page pairs only their high half.
	always @(posedge I_CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			search_process_id_q  <= {PID_W{1'b0}};
			sas_q   <= 1'b0;
			sgs_q   <= 1'b0;
			slpid_q <= {LPID_W{1'b0}};
			tgs_q   <= 1'b0;
			vf_q    <= 1'b0;
			entry_partition_id_q <= {LPID_W{1'b0}};
			rpu_q   <= {RPU_W{1'b0}};
		end
		else
		begin
			if (w_srch)
			begin
				search_process_id_q <= d_srch[`TSXR_SRCH_PID_LO +: PID_W];
				sas_q  <= d_srch[`TSXR_SRCH_AS];
			end
			if (w_hs)
			begin
				sgs_q   <= d_hs[`TSXR_HS_GS];
				slpid_q <= d_hs[`TSXR_TAG_LPID_LO +: LPID_W];
			end
			if (w_tag)
			begin
				tgs_q   <= d_tag[`TSXR_TAG_GS];
				vf_q    <= d_tag[`TSXR_TAG_VF];
				entry_partition_id_q <= d_tag[`TSXR_TAG_LPID_LO +: LPID_W];
			end
			if (w_rph)
				rpu_q <= d_rph[RPU_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// External load and store contexts.
	// ----------------------------------------------------------------
	wire [31:0]       ld_img;   // Load context read image.
	wire [31:0]       st_img;   // Store context read image.
	wire              ld_pr;
	wire              ld_as;
	wire              ld_gs;
	wire [LPID_W-1:0] ld_lpid;
	wire [PID_W-1:0]  ld_pid;
	wire              st_pr;
	wire              st_as;
	wire              st_gs;
	wire [LPID_W-1:0] st_lpid;
	wire [PID_W-1:0]  st_pid;

	tsxr_ctx_field #(.PID_W(PID_W), .LPID_W(LPID_W)) u_ld (
		.clk    (I_CORE_CLK),
		.rst_n  (rst_n),
		.wr     (w_ld),
		.hv     (I_HV_STATE),
		.wdata  (wl),
		.rdata  (ld_img),
		.pr_q   (ld_pr),
		.as_q   (ld_as),
		.gs_q   (ld_gs),
		.lpid_q (ld_lpid),
		.pid_q  (ld_pid)
	);

	tsxr_ctx_field #(.PID_W(PID_W), .LPID_W(LPID_W)) u_st (
		.clk    (I_CORE_CLK),
		.rst_n  (rst_n),
		.wr     (w_st),
		.hv     (I_HV_STATE),
		.wdata  (wl),
		.rdata  (st_img),
		.pr_q   (st_pr),
		.as_q   (st_as),
		.gs_q   (st_gs),
		.lpid_q (st_lpid),
		.pid_q  (st_pid)
	);

	// ----------------------------------------------------------------
	// Read images; unimplemented bits read as zero.
	// ----------------------------------------------------------------
	wire [31:0] srch_img = {2'b00, {(14-PID_W){1'b0}}, search_process_id_q,
		15'h0000, sas_q};
	wire [31:0] hs_img   = {sgs_q, 19'h0_0000, {(12-LPID_W){1'b0}}, slpid_q};
	wire [31:0] tag_img  = {tgs_q, vf_q, 18'h0_0000,
		{(12-LPID_W){1'b0}}, entry_partition_id_q};
	wire [31:0] rph_img  = {{(32-RPU_W){1'b0}}, rpu_q};

	// Read mux; pairs return all 64 bits on any read that is not denied.
	reg [63:0] rd_d;
	always @*
	begin
		case (I_SPR_NUM)
			`TSXR_SPR_SRCH:   rd_d = {32'h0000_0000, srch_img};
			`TSXR_SPR_HSRCH:  rd_d = {32'h0000_0000, hs_img};
			`TSXR_SPR_TAG:    rd_d = {32'h0000_0000, tag_img};
			`TSXR_SPR_RPH:    rd_d = {32'h0000_0000, rph_img};
			`TSXR_SPR_LDCTX:  rd_d = {32'h0000_0000, ld_img};
			`TSXR_SPR_STCTX:  rd_d = {32'h0000_0000, st_img};
			`TSXR_SPR_P_SEL:  rd_d = {I_SEL_REG, I_ECTL_REG};
			`TSXR_SPR_P_RPN:  rd_d = {rph_img, I_RPL_REG};
			`TSXR_SPR_P_SRCH: rd_d = {hs_img, srch_img};
			`TSXR_SPR_P_TAG:  rd_d = {tag_img, I_ECTL_REG};
			default:          rd_d = 64'h0000_0000_0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Move port answer, one cycle after the request.
	// ----------------------------------------------------------------
	always @(posedge I_CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			O_SPR_RDATA <= 64'h0000_0000_0000_0000;
			O_SPR_ACK   <= 1'b0;
			O_PRIV_EXC  <= 1'b0;
			O_SEL_WR    <= 1'b0;
			O_ECTL_WR   <= 1'b0;
			O_RPL_WR    <= 1'b0;
			// Reset clears both sibling data buses to zero.
			O_SIB_WDATA <= `TSXR_RST_WORD;
			O_SEL_WDATA <= `TSXR_RST_WORD;
		end
		else
		begin
			O_SPR_ACK  <= acc;
			O_PRIV_EXC <= denied;
			// A denied read returns zero.
			O_SPR_RDATA <= (I_SPR_RD & ~denied) ? rd_d : 64'h0000_0000_0000_0000;
			// Select, tag and page pair writes forward their low halves to the siblings.
			O_SEL_WR  <= wr_ok & (I_SPR_NUM == `TSXR_SPR_P_SEL);
			O_ECTL_WR <= wr_ok & ((I_SPR_NUM == `TSXR_SPR_P_SEL) ||
				(I_SPR_NUM == `TSXR_SPR_P_TAG));
			O_RPL_WR  <= wr_ok & (I_SPR_NUM == `TSXR_SPR_P_RPN);
			// Select takes the high word on a bus of its own, so a select
			// pair lands both halves in one cycle; entry control and real
			// page low always take the low word. The data buses follow the
			// request every cycle and only the strobes say when they count.
			O_SEL_WDATA <= wh;
			O_SIB_WDATA <= wl;
		end
	end

	// ----------------------------------------------------------------
	// Translation context selection and matching.
	// An external load or store swaps in its own context for one lookup;
	// the load strobe wins if both are raised. Results are registered, so
	// a candidate entry shown at one edge is judged at the next one, and
	// the guest and partition fields only move under hypervisor writes.
	// ----------------------------------------------------------------
	reg               e_pr;
	reg               e_as;
	reg               e_gs;
	reg  [LPID_W-1:0] e_lpid;
	reg  [PID_W-1:0]  e_pid;

	// External loads and stores swap in their own context.
	always @*
	begin
		e_pr   = I_MSR_PR;
		e_as   = I_MSR_DS;
		e_gs   = I_MSR_GS;
		e_lpid = I_PART_ID;
		e_pid  = I_CUR_PID;
		if (I_EXT_LD)
		begin
			e_pr   = ld_pr;
			e_as   = ld_as;
			e_gs   = ld_gs;
			e_lpid = ld_lpid;
			e_pid  = ld_pid;
		end
		else if (I_EXT_ST)
		begin
			e_pr   = st_pr;
			e_as   = st_as;
			e_gs   = st_gs;
			e_lpid = st_lpid;
			e_pid  = st_pid;
		end
	end

	// Partition zero in an entry is global.
	wire lpid_x = (I_ENT_LPID == {LPID_W{1'b0}}) | (I_ENT_LPID == e_lpid);
	wire lpid_s = (I_ENT_LPID == {LPID_W{1'b0}}) | (I_ENT_LPID == slpid_q);

	// Registered results.
	always @(posedge I_CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			O_SEARCH_HIT <= 1'b0;
			O_XLATE_HIT  <= 1'b0;
			O_EFF_PR     <= 1'b0;
			O_VF_DSI     <= 1'b0;
			O_RPN_UPPER  <= {RPU_W{1'b0}};
			O_TAG_GS     <= 1'b0;
			O_TAG_LPID   <= {LPID_W{1'b0}};
		end
		else
		begin
			O_SEARCH_HIT <= (I_ENT_PID == search_process_id_q) & (I_ENT_TS == sas_q) &
				(I_ENT_TGS == sgs_q) & lpid_s;
			O_XLATE_HIT  <= (I_ENT_PID == e_pid) & (I_ENT_TS == e_as) &
				(I_ENT_TGS == e_gs) & lpid_x;
			O_EFF_PR     <= e_pr;
			O_VF_DSI     <= I_DATA_ACC & vf_q;
			O_RPN_UPPER  <= rpu_q;
			O_TAG_GS     <= tgs_q;
			O_TAG_LPID   <= entry_partition_id_q;
		end
	end

endmodule

// [logic/tsxr_regs.vh]
`ifndef TSXR_REGS_VH
`define TSXR_REGS_VH

// ----------------------------------------------------------------
// Register numbers
// ----------------------------------------------------------------
`define TSXR_SPR_TAG      10'h155
`define TSXR_SPR_P_SRCH   10'h15C
`define TSXR_SPR_P_TAG    10'h15D
`define TSXR_SPR_P_RPN    10'h174
`define TSXR_SPR_P_SEL    10'h175
`define TSXR_SPR_SRCH     10'h270
`define TSXR_SPR_RPH      10'h3B0
`define TSXR_SPR_LDCTX    10'h3B3
`define TSXR_SPR_STCTX    10'h3B4
`define TSXR_SPR_HSRCH    10'h153
`define TSXR_SPR_SEL      10'h270
`define TSXR_SPR_ECTL     10'h271
`define TSXR_SPR_RPL      10'h273

// ----------------------------------------------------------------
// Field positions, counted from bit 0 at the least significant end
// ----------------------------------------------------------------
`define TSXR_SRCH_PID_LO  16
`define TSXR_SRCH_AS      0
`define TSXR_TAG_GS       31
`define TSXR_TAG_VF       30
`define TSXR_TAG_LPID_LO  0
`define TSXR_HS_GS        31
`define TSXR_CTX_PR       31
`define TSXR_CTX_AS       30
`define TSXR_CTX_GS       29
`define TSXR_CTX_LPID_LO  16
`define TSXR_CTX_PID_LO   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TSXR_RST_WORD     32'h0000_0000

`endif

// [logic/tsxr_ctx_field.v]
`timescale 1ns/1ps
`include "tsxr_regs.vh"

// ----------------------------------------------------------------
// One external context register (load or store).
// ----------------------------------------------------------------
module tsxr_ctx_field #(
	parameter PID_W  = 14,
	parameter LPID_W = 12
)(
	input  wire                  clk,       // Core clock.
	input  wire                  rst_n,     // Synchronised reset.
	input  wire                  wr,        // Write strobe.
	input  wire                  hv,        // Writer is in hypervisor state.
	input  wire [31:0]           wdata,     // Low word written.
	output wire [31:0]           rdata,     // Read image, unused bits zero.
	output reg                   pr_q,      // Privilege stand-in.
	output reg                   as_q,      // Address space stand-in.
	output reg                   gs_q,      // Guest state stand-in.
	output reg  [LPID_W-1:0]     lpid_q,    // Partition ID stand-in.
	output reg  [PID_W-1:0]      pid_q      // Process ID stand-in.
);

	// ----------------------------------------------------------------
	// Storage; guest writes keep the hypervisor-owned fields.
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pr_q   <= 1'b0;
			as_q   <= 1'b0;
			gs_q   <= 1'b0;
			lpid_q <= {LPID_W{1'b0}};
			pid_q  <= {PID_W{1'b0}};
		end
		else if (wr)
		begin
			pr_q  <= wdata[`TSXR_CTX_PR];
			as_q  <= wdata[`TSXR_CTX_AS];
			pid_q <= wdata[`TSXR_CTX_PID_LO +: PID_W];
			if (hv)
			begin
				gs_q   <= wdata[`TSXR_CTX_GS];
				lpid_q <= wdata[`TSXR_CTX_LPID_LO +: LPID_W];
			end
		end
	end

	// Reserved and unimplemented bits read as zero.
	assign rdata = {pr_q, as_q, gs_q, 1'b0,
		{(12-LPID_W){1'b0}}, lpid_q, 2'b00,
		{(14-PID_W){1'b0}}, pid_q};

endmodule

// [sim/tsxr_checker.sv]
`timescale 1ns/1ps
// ------
// Protocol checker for the register bank ports.
// ------
module tsxr_checker #(
	parameter PID_W  = 14,
	parameter LPID_W = 12,
	parameter RPU_W  = 8
)(
	// Clock, reset, move port and data access.
	input wire              I_CORE_CLK,
	input wire              I_RSTN,
	input wire              I_SPR_WR,
	input wire              I_SPR_RD,
	input wire [9:0]        I_SPR_NUM,
	input wire [63:0]       I_SPR_WDATA,
	input wire              I_HV_STATE,
	input wire              I_DATA_ACC,
	// Observed outputs.
	input wire [63:0]       O_SPR_RDATA,
	input wire              O_SPR_ACK,
	input wire              O_PRIV_EXC,
	input wire              O_SEL_WR,
	input wire              O_ECTL_WR,
	input wire              O_RPL_WR,
	input wire [31:0]       O_SIB_WDATA,
	input wire [31:0]       O_SEL_WDATA,
	input wire              O_VF_DSI,
	input wire              O_TAG_GS,
	input wire [LPID_W-1:0] O_TAG_LPID
);
	// Any move request, and the numbers that only the hypervisor may touch.
	wire rq  = I_SPR_WR | I_SPR_RD;
	wire hvn = (I_SPR_NUM == 10'h155) | (I_SPR_NUM == 10'h15C) |
	           (I_SPR_NUM == 10'h15D) | (I_SPR_NUM == 10'h153);

	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_RSTN);

	// ------
	// Assertions.
	// ------
	ack_follows_a: assert property (rq |=> O_SPR_ACK)
		else $error("request without acknowledge");
	ack_only_a: assert property (!rq |=> !O_SPR_ACK)
		else $error("acknowledge without request");
	guest_denied_a: assert property (rq && !I_HV_STATE && hvn |=>
		O_PRIV_EXC && O_SPR_RDATA == 64'h0000_0000_0000_0000)
		else $error("guest reached a hypervisor number");
	access_allowed_a: assert property (rq && (I_HV_STATE || !hvn) |=> !O_PRIV_EXC)
		else $error("allowed access raised an exception");
	tag_write_a: assert property (I_SPR_WR && I_HV_STATE && I_SPR_NUM == 10'h155 |=>
		##1 O_TAG_GS == $past(I_SPR_WDATA[31], 2) &&
		O_TAG_LPID == $past(I_SPR_WDATA[LPID_W-1:0], 2))
		else $error("tag fields not loaded");
	tag_guest_a: assert property (I_SPR_WR && !I_HV_STATE && I_SPR_NUM == 10'h155 |=>
		$stable(O_TAG_LPID) [*2])
		else $error("guest write changed the tag");
	pair_select_a: assert property (I_SPR_WR && I_SPR_NUM == 10'h175 |=>
		O_SEL_WR && O_ECTL_WR && O_SEL_WDATA == $past(I_SPR_WDATA[63:32]) &&
		O_SIB_WDATA == $past(I_SPR_WDATA[31:0]))
		else $error("select pair write wrong");
	pair_page_a: assert property (I_SPR_WR && I_SPR_NUM == 10'h174 |=>
		O_RPL_WR && O_SIB_WDATA == $past(I_SPR_WDATA[31:0]))
		else $error("page pair write wrong");
	ectl_guest_a: assert property (I_SPR_WR && !I_HV_STATE && I_SPR_NUM == 10'h15D |=>
		!O_ECTL_WR)
		else $error("guest pair write passed through");
	fault_idle_a: assert property (!I_DATA_ACC |=> !O_VF_DSI)
		else $error("fault without data access");

	// Main scenarios reached.
	cover property (rq && !I_HV_STATE && hvn);
	cover property (I_SPR_WR && I_SPR_NUM == 10'h175);
	cover property (O_VF_DSI);
endmodule

bind tsxr_top tsxr_checker #(.PID_W(PID_W), .LPID_W(LPID_W), .RPU_W(RPU_W)) u_chk (
	.I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .I_SPR_WR(I_SPR_WR), .I_SPR_RD(I_SPR_RD),
	.I_SPR_NUM(I_SPR_NUM), .I_SPR_WDATA(I_SPR_WDATA), .I_HV_STATE(I_HV_STATE),
	.I_DATA_ACC(I_DATA_ACC), .O_SPR_RDATA(O_SPR_RDATA), .O_SPR_ACK(O_SPR_ACK),
	.O_PRIV_EXC(O_PRIV_EXC), .O_SEL_WR(O_SEL_WR), .O_ECTL_WR(O_ECTL_WR), .O_RPL_WR(O_RPL_WR),
	.O_SIB_WDATA(O_SIB_WDATA), .O_VF_DSI(O_VF_DSI), .O_TAG_GS(O_TAG_GS), .O_TAG_LPID(O_TAG_LPID),
	.O_SEL_WDATA(O_SEL_WDATA));

// [sim/tsxr_top_tb.sv]
`timescale 1ns/1ps
module tsxr_top_tb;
	// ------
	// Bench signals.
	// ------
	reg         clk, rstn, wr, rd, hv, ext_ld, ext_st, dacc, ms_pr, ms_ds, ms_gs, e_ts, e_tgs, ev;
	reg  [9:0]  num, cn;
	reg  [63:0] wdata, rv;
	reg  [31:0] sel_r, ectl_r, rpl_r;
	reg  [13:0] e_pid, cur_pid;
	reg  [11:0] e_lpid, part;
	wire [63:0] rdata;
	wire [31:0] sib_d, sel_d;
	wire [11:0] tag_lpid;
	wire [7:0]  rpu;
	wire        ack, exc, sel_wr, ectl_wr, rpl_wr, s_hit, x_hit, eff_pr, dsi, tag_gs;
	integer     n_errors, cmp_count, cyc, i;

	tsxr_top #(.PID_W(14), .LPID_W(12), .RPU_W(8)) dut (
		.I_CORE_CLK(clk), .I_RSTN(rstn), .I_SPR_WR(wr), .I_SPR_RD(rd), .I_SPR_NUM(num),
		.I_SPR_WDATA(wdata), .I_HV_STATE(hv), .O_SPR_RDATA(rdata), .O_SPR_ACK(ack),
		.O_PRIV_EXC(exc), .I_SEL_REG(sel_r), .I_ECTL_REG(ectl_r), .I_RPL_REG(rpl_r),
		.O_SEL_WR(sel_wr), .O_ECTL_WR(ectl_wr), .O_RPL_WR(rpl_wr), .O_SIB_WDATA(sib_d),
		.O_SEL_WDATA(sel_d),
		.I_ENT_PID(e_pid), .I_ENT_TS(e_ts), .I_ENT_TGS(e_tgs), .I_ENT_LPID(e_lpid),
		.I_MSR_PR(ms_pr), .I_MSR_DS(ms_ds), .I_MSR_GS(ms_gs), .I_PART_ID(part),
		.I_CUR_PID(cur_pid), .I_EXT_LD(ext_ld), .I_EXT_ST(ext_st), .I_DATA_ACC(dacc),
		.O_SEARCH_HIT(s_hit), .O_XLATE_HIT(x_hit), .O_EFF_PR(eff_pr), .O_VF_DSI(dsi),
		.O_RPN_UPPER(rpu), .O_TAG_GS(tag_gs), .O_TAG_LPID(tag_lpid));

	// ------
	// Shared tasks.
	// ------
	// Case equality, so an unknown never passes.
	task chk(input [63:0] got, input [63:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			n_errors = n_errors + 1;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	end
	endtask

	// Steps past the next edge so its updates have landed.
	task tick;
	begin
		@(posedge clk);
		#1;
	end
	endtask

	// One move request, held for the taking edge; answer read in the acknowledge cycle.
	task acc(input w, input h, input [9:0] n, input [63:0] d);
	begin
		@(posedge clk);
		wr    <= w;
		rd    <= !w;
		hv    <= h;
		num   <= n;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		rv = rdata;
		ev = exc;
		chk(ack, 1);
	end
	endtask

	// Presents a candidate entry; the match is registered on the following edge.
	task ent(input [13:0] p, input ts, input entry_guest_space, input [11:0] lp);
	begin
		@(posedge clk);
		e_pid  <= p;
		e_ts   <= ts;
		e_tgs  <= entry_guest_space;
		e_lpid <= lp;
		tick;
	end
	endtask

	task finish_test;
	begin
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask

	// ------
	// Scenarios.
	// ------
	// Search context from guest state, with reserved bits written as ones.
	task t_search;
	begin
		acc(0, 1, 10'h3B3, 64'h0);
		chk(rv, 0);
		acc(1, 0, 10'h270, 64'hFFFF_FFFF_FFFF_FFFF);
		chk(ev, 0);
		acc(0, 0, 10'h270, 64'h0);
		chk(rv, 64'h0000_0000_3FFF_0001);
		ent(14'h3FFF, 1, 0, 12'h000);
		chk(s_hit, 1);
		ent(14'h3FFE, 1, 0, 12'h000);
		chk(s_hit, 0);
		ent(14'h3FFF, 0, 0, 12'h000);
		chk(s_hit, 0);
	end
	endtask

	// Real page high alone and through its pair.
	task t_page;
	begin
		acc(1, 0, 10'h3B0, 64'h0000_0000_0000_0312);
		acc(0, 0, 10'h3B0, 64'h0);
		chk(rv, 64'h0000_0000_0000_0012);
		chk(rpu, 8'h12);
		acc(1, 0, 10'h174, 64'h0000_00A7_ABCD_1234);
		chk({rpl_wr, sib_d}, 33'h1_ABCD_1234);
		acc(0, 0, 10'h174, 64'h0);
		chk(rv, 64'h0000_00A7_5555_AAAA);
		chk(rpu, 8'hA7);
	end
	endtask

	// Tag register: refused to the guest, then loaded by the hypervisor.
	task t_tag;
	begin
		acc(1, 0, 10'h155, 64'h0000_0000_FFFF_FABC);
		chk(ev, 1);
		tick;
		chk({tag_gs, tag_lpid}, 0);
		acc(1, 1, 10'h155, 64'h0000_0000_FFFF_FABC);
		chk(ev, 0);
		tick;
		chk({tag_gs, tag_lpid}, 13'h1ABC);
		acc(0, 1, 10'h155, 64'h0);
		chk(rv, 64'h0000_0000_C000_0ABC);
		acc(0, 0, 10'h155, 64'h0);
		chk({ev, rv[31:0]}, 33'h1_0000_0000);
		@(posedge clk);
		dacc <= 1'b1;
		tick;
		chk(dsi, 1);
		acc(1, 0, 10'h15D, 64'h0000_0005_1111_2222);
		chk({ev, ectl_wr}, 2'b10);
		acc(1, 1, 10'h15D, 64'h0000_0005_1111_2222);
		chk({ectl_wr, sib_d}, 33'h1_1111_2222);
		tick;
		chk({dsi, tag_gs, tag_lpid}, 14'h0005);
		acc(0, 1, 10'h15D, 64'h0);
		chk(rv, 64'h0000_0005_8765_4321);
		@(posedge clk);
		dacc <= 1'b0;
	end
	endtask

	// Select pair and the hypervisor search pair.
	task t_pairs;
	begin
		acc(1, 0, 10'h175, 64'h1234_5678_0BAD_F00D);
		chk({sel_wr, ectl_wr, sib_d}, 34'h3_0BAD_F00D);
		chk(sel_d, 32'h1234_5678);
		acc(0, 0, 10'h175, 64'h0);
		chk(rv, 64'hA5A5_0001_8765_4321);
		acc(0, 0, 10'h15C, 64'h0);
		chk({ev, rv[31:0]}, 33'h1_0000_0000);
		acc(1, 0, 10'h153, 64'h0);
		chk(ev, 1);
		acc(1, 1, 10'h15C, 64'hFFFF_FFFF_0123_0000);
		acc(0, 1, 10'h15C, 64'h0);
		chk(rv, 64'h8000_0FFF_0123_0000);
		ent(14'h0123, 0, 1, 12'hFFF);
		chk(s_hit, 1);
		ent(14'h0123, 0, 0, 12'hFFF);
		chk(s_hit, 0);
		ent(14'h0123, 0, 1, 12'h001);
		chk(s_hit, 0);
	end
	endtask

	// Load and then store context: guarded fields and substitution in translation.
	task t_ext;
	begin
		for (i = 0; i < 2; i = i + 1)
		begin
			cn = (i == 0) ? 10'h3B3 : 10'h3B4;
			acc(1, 1, cn, 64'h0000_0000_F05A_C2BC);
			acc(0, 0, cn, 64'h0);
			chk(rv, 64'h0000_0000_E05A_02BC);
			acc(1, 0, cn, 64'h0000_0000_0000_0111);
			acc(0, 0, cn, 64'h0);
			chk(rv, 64'h0000_0000_205A_0111);
			@(posedge clk);
			ext_ld <= (i == 0);
			ext_st <= (i == 1);
			ent(14'h0111, 0, 1, 12'h05A);
			chk({x_hit, eff_pr}, 2'b10);
			ent(14'h0111, 0, 1, 12'h000);
			chk(x_hit, 1);
			ent(14'h0111, 0, 1, 12'h05B);
			chk(x_hit, 0);
			ent(14'h0111, 1, 1, 12'h05A);
			chk(x_hit, 0);
			@(posedge clk);
			ext_ld <= 1'b0;
			ext_st <= 1'b0;
			ent(14'h0111, 0, 1, 12'h05A);
			chk({x_hit, eff_pr}, 2'b01);
			ent(14'h3FFF, 1, 0, 12'h777);
			chk(x_hit, 1);
			ent(14'h3FFF, 1, 1, 12'h777);
			chk(x_hit, 0);
		end
	end
	endtask

	// ------
	// Clock, timeout and main sequence.
	// ------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// A hang costs one mismatch and ends the run.
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc == 5000)
		begin
			n_errors = n_errors + 1;
			finish_test;
		end
	end

	initial
	begin
		{rstn, wr, rd, hv, ext_ld, ext_st, dacc, ms_gs, e_ts, e_tgs} = 10'h000;
		{ms_pr, ms_ds} = 2'b11;
		{num, wdata, e_pid, e_lpid} = 0;
		{sel_r, ectl_r, rpl_r} = {32'hA5A5_0001, 32'h8765_4321, 32'h5555_AAAA};
		cur_pid = 14'h3FFF;
		part = 12'h777;
		{n_errors, cmp_count, cyc} = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_search;
		t_page;
		t_tag;
		t_pairs;
		t_ext;
		finish_test;
	end
endmodule
